// *** hw/rx_cfg_pkg.sv ***
// Constants shared by the receiver configuration block and its helpers.
package rx_cfg_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'h35;
    localparam logic [7:0] IDX_BLANK = 8'h36;
    localparam logic [7:0] IDX_THRESH = 8'h37;
    localparam logic [7:0] IDX_INPUT = 8'h38;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
    localparam logic [7:0] IDX_STATE = 8'h52;
    // Values after reset.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BLANK_RST = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'h00;
    localparam logic [7:0] INPUT_RST = 8'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Writable bits; every other bit is reserved and reads as zero.
    localparam logic [7:0] CTRL_WMASK = 8'hCF;
    localparam logic [7:0] BLANK_WMASK = 8'hFF;
    localparam logic [7:0] THRESH_WMASK = 8'hFF;
    localparam logic [7:0] INPUT_WMASK = 8'hF3;
    // Field positions.
    localparam int CTRL_PARTIAL = 7;
    localparam int CTRL_CONT = 6;
    localparam int CTRL_SUPPRESS = 3;
    localparam int CTRL_RATE_LSB = 0;
    localparam int BLANK_UNIT = 7;
    localparam int BLANK_TIME_LSB = 0;
    localparam int THRESH_DEC_LSB = 4;
    localparam int THRESH_PHASE_LSB = 0;
    localparam int INPUT_SINGLE = 7;
    localparam int INPUT_CONV = 6;
    localparam int INPUT_SRC_LSB = 4;
    localparam int INPUT_COLL_LSB = 0;
    // Receive rate codes and collision threshold codes.
    localparam logic [2:0] RATE_106 = 3'h4;
    localparam logic [2:0] RATE_212 = 3'h5;
    localparam logic [2:0] RATE_424 = 3'h6;
    localparam logic [2:0] RATE_847 = 3'h7;
    localparam logic [1:0] COLL_OFF = 2'h3;
    // Bytes screened by interference suppression at the start of a frame.
    localparam logic [1:0] SUPPRESS_BYTES = 2'h3;
    // Interrupt status and mask bit positions.
    localparam int IRQ_RX_DONE = 0;
    localparam int IRQ_DISCARD = 1;
    localparam int IRQ_BLANK_END = 2;
    // Clock and carrier timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int CARRIER_KHZ = 13560;
    localparam int FINE_UNIT_CARRIER = 16;
    // Half a data bit in carrier periods for each bit stream rate.
    localparam int HALF_BIT_CARRIER_106 = 64;
    localparam int HALF_BIT_CARRIER_212 = 32;
    localparam int HALF_BIT_CARRIER_424 = 16;
    localparam int HALF_BIT_CARRIER_847 = 8;
    localparam int NS_PER_CARRIER_DIV = CARRIER_KHZ * CLK_PERIOD_NS;
    // Least times, rounded up to whole clock cycles.
    localparam int FINE_UNIT_CYC = (FINE_UNIT_CARRIER * 1000000
        + NS_PER_CARRIER_DIV - 1) / NS_PER_CARRIER_DIV;
    localparam int HB_106_CYC = (HALF_BIT_CARRIER_106 * 1000000
        + NS_PER_CARRIER_DIV - 1) / NS_PER_CARRIER_DIV;
    localparam int HB_212_CYC = (HALF_BIT_CARRIER_212 * 1000000
        + NS_PER_CARRIER_DIV - 1) / NS_PER_CARRIER_DIV;
    localparam int HB_424_CYC = (HALF_BIT_CARRIER_424 * 1000000
        + NS_PER_CARRIER_DIV - 1) / NS_PER_CARRIER_DIV;
    localparam int HB_847_CYC = (HALF_BIT_CARRIER_847 * 1000000
        + NS_PER_CARRIER_DIV - 1) / NS_PER_CARRIER_DIV;
endpackage

// *** hw/blanking_timer.sv ***
// Post-transmit input blanking timer counted in programmable time units.
module blanking_timer (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [6:0] units,
    input wire logic [7:0] unit_cycles,
    output logic active
);
    logic [6:0] unit_cnt_r;
    logic [7:0] pre_r;

    // Loads on the end of transmission, then counts units down to zero.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            unit_cnt_r <= 7'h00;
            pre_r <= 8'h00;
        end
        else if (start)
        begin
            unit_cnt_r <= units;
            pre_r <= unit_cycles - 8'h01;
        end
        else if (unit_cnt_r != 7'h00)
        begin
            if (pre_r == 8'h00)
            begin
                unit_cnt_r <= unit_cnt_r - 7'h01;
                pre_r <= unit_cycles - 8'h01;
            end
            else
            begin
                pre_r <= pre_r - 8'h01;
            end
        end
    end

    // Input is blanked while any unit remains.
    assign active = unit_cnt_r != 7'h00;
endmodule

// *** hw/suppress_hold.sv ***
// Three-byte holding store for the start of a frame under suppression.
module suppress_hold (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic drop,
    input wire logic release_req,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic [1:0] count,
    output logic draining
);
    logic [7:0] mem_r [0:2];
    logic [1:0] wr_cnt_r;
    logic [1:0] rd_ptr_r;
    logic drain_r;
    logic out_valid_r;
    logic [7:0] out_data_r;

    // Stores pushed bytes, then replays them one per cycle on release.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            wr_cnt_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            drain_r <= 1'h0;
        end
        else if (drop)
        begin
            wr_cnt_r <= 2'h0;
            drain_r <= 1'h0;
        end
        else if (drain_r)
        begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
            if (rd_ptr_r == wr_cnt_r - 2'h1)
            begin
                drain_r <= 1'h0;
                wr_cnt_r <= 2'h0;
            end
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_cnt_r] <= push_data;
                wr_cnt_r <= wr_cnt_r + 2'h1;
            end
            if (release_req)
            begin
                drain_r <= 1'h1;
                rd_ptr_r <= 2'h0;
            end
        end
    end

    // Replayed bytes leave through a register.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            out_valid_r <= 1'h0;
            out_data_r <= 8'h00;
        end
        else
        begin
            out_valid_r <= drain_r && !drop;
            out_data_r <= mem_r[rd_ptr_r];
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
    assign count = wr_cnt_r;
    assign draining = drain_r;
endmodule

// *** hw/rx_frontend_config.sv ***
// Receiver configuration registers and receive stream control.
// Operation
// - Partial final byte is stored when partial storing is on, despite CRC.
// - Continuous receive keeps the receiver active after each frame end.
// - Continuous receive appends an error register copy after each frame except a suppressed short frame.
// - Suppression drops the first three bytes on error and resets the FIFO.
// - A collision in the first three bytes counts as an error.
// - Suppression with short frame after valid start gives no completion.
// - Rate codes 4h to 7h give 106, 212, 424, 847 kBd; others reserved.
// - Input is ignored after transmit for the programmed blanking time.
// - Blanking unit is 16 carrier periods, or half a data bit when set.
// - Upper threshold nibble sets the least level the bit decoder accepts.
// - Lower threshold nibble sets the phase detector least level.
// - Topology bit selects fully differential or single positive input.
// - Converter bit selects normal reception or low power card detect.
// - Source field selects idle, analog, envelope or generic digital input.
// - Collision threshold codes 1/8, 1/4, 1/2; code 3h disables detection.
// - Half-bit unit follows the transmit data configuration bit rate.
module rx_frontend_config (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_end,
    input wire logic sof_valid,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    input wire logic [2:0] byte_bits,
    input wire logic byte_error,
    input wire logic collision_seen,
    input wire logic frame_end,
    input wire logic crc_enable,
    input wire logic [7:0] error_snapshot,
    input wire logic [2:0] transmit_data_config,
    output logic fifo_wr_valid,
    output logic [7:0] fifo_wr_data,
    output logic fifo_reset,
    output logic receiver_active,
    output logic decoder_enable,
    output logic [3:0] decoder_threshold,
    output logic [3:0] phase_detector_threshold,
    output logic single_input_mode,
    output logic converter_mode,
    output logic [1:0] signal_source_select,
    output logic [1:0] collision_threshold,
    output logic collision_detect_en,
    output logic [2:0] rx_rate_code,
    output logic rx_rate_valid,
    output logic irq
);
    // True for the four defined bit rate codes.
    function automatic logic rate_ok(input logic [2:0] code);
        rate_ok = code == rx_cfg_pkg::RATE_106
            || code == rx_cfg_pkg::RATE_212
            || code == rx_cfg_pkg::RATE_424
            || code == rx_cfg_pkg::RATE_847;
    endfunction

    // Clock cycles in half a data bit; reserved codes fall back to 106 kBd.
    function automatic logic [7:0] half_bit_cyc(input logic [2:0] code);
        logic [7:0] cyc;
        cyc = 8'(rx_cfg_pkg::HB_106_CYC);
        if (code == rx_cfg_pkg::RATE_212)
            cyc = 8'(rx_cfg_pkg::HB_212_CYC);
        else if (code == rx_cfg_pkg::RATE_424)
            cyc = 8'(rx_cfg_pkg::HB_424_CYC);
        else if (code == rx_cfg_pkg::RATE_847)
            cyc = 8'(rx_cfg_pkg::HB_847_CYC);
        half_bit_cyc = cyc;
    endfunction

    logic [7:0] ctrl_r;
    logic [7:0] blank_r;
    logic [7:0] thresh_r;
    logic [7:0] input_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_stat_nxt;
    logic [2:0] irq_mask_r;
    logic [31:0] prdata_r;
    logic [7:0] idx;
    logic mapped;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;
    logic active_r;
    logic sof_seen_r;
    logic [1:0] frame_cnt_r;
    logic err_pend_r;
    logic [7:0] err_byte_r;
    logic fifo_valid_r;
    logic [7:0] fifo_data_r;
    logic fifo_reset_r;
    logic blanking;
    logic blank_d_r;
    logic [7:0] unit_cycles;
    logic take;
    logic bad;
    logic hold_en;
    logic partial_drop;
    logic discard_hit;
    logic hold_push;
    logic hold_release;
    logic direct_wr;
    logic fend;
    logic short_frame;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic hold_valid;
    logic [7:0] hold_data;
    logic [1:0] hold_count;
    logic hold_draining;

    // Bus decode: word-aligned addresses only, index is address over four.
    assign idx = paddr[9:2];
    assign mapped = paddr[1:0] == 2'h0
        && (idx == rx_cfg_pkg::IDX_CTRL || idx == rx_cfg_pkg::IDX_BLANK
        || idx == rx_cfg_pkg::IDX_THRESH || idx == rx_cfg_pkg::IDX_INPUT
        || idx == rx_cfg_pkg::IDX_IRQ_STAT
        || idx == rx_cfg_pkg::IDX_IRQ_MASK
        || idx == rx_cfg_pkg::IDX_STATE);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign rd_acc = psel && penable && !pwrite && mapped;
    assign wbyte = pwdata[7:0];
    assign pready = 1'h1;
    assign pslverr = psel && penable && !mapped;

    // Configuration registers; reserved bits are masked off on write.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ctrl_r <= rx_cfg_pkg::CTRL_RST;
            blank_r <= rx_cfg_pkg::BLANK_RST;
            thresh_r <= rx_cfg_pkg::THRESH_RST;
            input_r <= rx_cfg_pkg::INPUT_RST;
            irq_mask_r <= rx_cfg_pkg::IRQ_RST;
        end
        else if (wr_acc)
        begin
            if (idx == rx_cfg_pkg::IDX_CTRL)
                ctrl_r <= wbyte & rx_cfg_pkg::CTRL_WMASK;
            if (idx == rx_cfg_pkg::IDX_BLANK)
                blank_r <= wbyte & rx_cfg_pkg::BLANK_WMASK;
            if (idx == rx_cfg_pkg::IDX_THRESH)
                thresh_r <= wbyte & rx_cfg_pkg::THRESH_WMASK;
            if (idx == rx_cfg_pkg::IDX_INPUT)
                input_r <= wbyte & rx_cfg_pkg::INPUT_WMASK;
            if (idx == rx_cfg_pkg::IDX_IRQ_MASK)
                irq_mask_r <= wbyte[2:0];
        end
    end

    // Read data is captured in the setup cycle and held for the access.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            prdata_r <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            prdata_r <= 32'h0000_0000;
            if (idx == rx_cfg_pkg::IDX_CTRL)
                prdata_r[7:0] <= ctrl_r;
            else if (idx == rx_cfg_pkg::IDX_BLANK)
                prdata_r[7:0] <= blank_r;
            else if (idx == rx_cfg_pkg::IDX_THRESH)
                prdata_r[7:0] <= thresh_r;
            else if (idx == rx_cfg_pkg::IDX_INPUT)
                prdata_r[7:0] <= input_r;
            else if (idx == rx_cfg_pkg::IDX_IRQ_STAT)
                prdata_r[2:0] <= irq_stat_r;
            else if (idx == rx_cfg_pkg::IDX_IRQ_MASK)
                prdata_r[2:0] <= irq_mask_r;
            else if (idx == rx_cfg_pkg::IDX_STATE)
                prdata_r[6:0] <= {rx_rate_valid, hold_draining, blanking,
                    active_r, err_pend_r, frame_cnt_r};
        end
    end
    assign prdata = prdata_r;

    // Decoded configuration fields driven to the analog and decoder logic.
    assign decoder_threshold = thresh_r[rx_cfg_pkg::THRESH_DEC_LSB +: 4];
    assign phase_detector_threshold =
        thresh_r[rx_cfg_pkg::THRESH_PHASE_LSB +: 4];
    assign single_input_mode = input_r[rx_cfg_pkg::INPUT_SINGLE];
    assign converter_mode = input_r[rx_cfg_pkg::INPUT_CONV];
    assign signal_source_select =
        input_r[rx_cfg_pkg::INPUT_SRC_LSB +: 2];
    assign collision_threshold = input_r[rx_cfg_pkg::INPUT_COLL_LSB +: 2];
    assign collision_detect_en =
        collision_threshold != rx_cfg_pkg::COLL_OFF;
    assign rx_rate_code = ctrl_r[rx_cfg_pkg::CTRL_RATE_LSB +: 3];
    assign rx_rate_valid = rate_ok(rx_rate_code);

    // Blanking unit: fixed carrier units or half a transmit data bit.
    assign unit_cycles = blank_r[rx_cfg_pkg::BLANK_UNIT]
        ? half_bit_cyc(transmit_data_config)
        : 8'(rx_cfg_pkg::FINE_UNIT_CYC);

    blanking_timer u_blank (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(tx_end),
        .units(blank_r[rx_cfg_pkg::BLANK_TIME_LSB +: 7]),
        .unit_cycles(unit_cycles),
        .active(blanking)
    );

    // The decoder runs only while receiving and not blanked.
    assign decoder_enable = active_r && !blanking;
    assign receiver_active = active_r;

    // Byte classification for the current received byte.
    assign take = byte_valid && decoder_enable;
    assign bad = byte_error
        || (collision_seen && collision_detect_en);
    assign hold_en = ctrl_r[rx_cfg_pkg::CTRL_SUPPRESS]
        && frame_cnt_r < rx_cfg_pkg::SUPPRESS_BYTES;
    assign partial_drop = byte_last && byte_bits != 3'h0 && crc_enable
        && !ctrl_r[rx_cfg_pkg::CTRL_PARTIAL];
    assign discard_hit = take && hold_en && bad;
    assign hold_push = take && hold_en && !bad && !partial_drop;
    assign hold_release = hold_push && hold_count == 2'h2;
    assign direct_wr = take && !hold_en && !partial_drop;
    assign fend = frame_end && active_r;
    assign short_frame = fend && sof_seen_r
        && ctrl_r[rx_cfg_pkg::CTRL_SUPPRESS]
        && frame_cnt_r < rx_cfg_pkg::SUPPRESS_BYTES;

    suppress_hold u_hold (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .push(hold_push),
        .push_data(byte_data),
        .drop(discard_hit || short_frame),
        .release_req(hold_release),
        .out_valid(hold_valid),
        .out_data(hold_data),
        .count(hold_count),
        .draining(hold_draining)
    );

    // Receiver on at transmit end; off at frame end unless continuous.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            active_r <= 1'h0;
        else if (tx_end)
            active_r <= 1'h1;
        else if (fend && !ctrl_r[rx_cfg_pkg::CTRL_CONT])
            active_r <= 1'h0;
    end

    // Frame tracking: start seen and bytes accepted, saturating at three.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sof_seen_r <= 1'h0;
            frame_cnt_r <= 2'h0;
        end
        else if (fend || discard_hit)
        begin
            sof_seen_r <= 1'h0;
            frame_cnt_r <= 2'h0;
        end
        else
        begin
            if (sof_valid)
                sof_seen_r <= 1'h1;
            if (take && !partial_drop
                && frame_cnt_r != rx_cfg_pkg::SUPPRESS_BYTES)
                frame_cnt_r <= frame_cnt_r + 2'h1;
        end
    end

    // Error byte waits until the data path is free after a frame end.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            err_pend_r <= 1'h0;
            err_byte_r <= 8'h00;
        end
        else if (fend && ctrl_r[rx_cfg_pkg::CTRL_CONT] && !short_frame)
        begin
            err_pend_r <= 1'h1;
            err_byte_r <= error_snapshot;
        end
        else if (err_pend_r && !hold_valid && !direct_wr)
            err_pend_r <= 1'h0;
    end

    // FIFO write port: replayed bytes, then direct bytes, then error byte.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            fifo_valid_r <= 1'h0;
            fifo_data_r <= 8'h00;
            fifo_reset_r <= 1'h0;
        end
        else
        begin
            fifo_reset_r <= discard_hit || short_frame;
            fifo_valid_r <= hold_valid || direct_wr || err_pend_r;
            if (hold_valid)
                fifo_data_r <= hold_data;
            else if (direct_wr)
                fifo_data_r <= byte_data;
            else
                fifo_data_r <= err_byte_r;
        end
    end
    assign fifo_wr_valid = fifo_valid_r;
    assign fifo_wr_data = fifo_data_r;
    assign fifo_reset = fifo_reset_r;

    // Delayed blanking level for the end-of-blanking event.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            blank_d_r <= 1'h0;
        else
            blank_d_r <= blanking;
    end

    // Sticky events; a read of the status clears it, a new event wins.
    always_comb
    begin
        irq_set = 3'h0;
        irq_set[rx_cfg_pkg::IRQ_RX_DONE] = fend && !short_frame;
        irq_set[rx_cfg_pkg::IRQ_DISCARD] = discard_hit || short_frame;
        irq_set[rx_cfg_pkg::IRQ_BLANK_END] = blank_d_r && !blanking;
        irq_clr = (rd_acc && idx == rx_cfg_pkg::IDX_IRQ_STAT)
            ? 3'h7 : 3'h0;
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            irq_stat_r <= rx_cfg_pkg::IRQ_RST;
        else
            irq_stat_r <= irq_stat_nxt;
    end

    // Level interrupt while any unmasked status bit stands.
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule

// *** verification/rx_cfg_monitor.sv ***
// Port checker for the receiver configuration block.
module rx_cfg_monitor (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic tx_end,
    input wire logic fifo_reset,
    input wire logic receiver_active,
    input wire logic decoder_enable,
    input wire logic [1:0] collision_threshold,
    input wire logic collision_detect_en,
    input wire logic [2:0] rx_rate_code,
    input wire logic rx_rate_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    // An access phase, and a read within it.
    sequence acc_s;
        psel && penable;
    endsequence
    sequence rd_s;
        acc_s ##0 !pwrite;
    endsequence
    // Each property ties an output to its cause.
    rate_valid_a: assert property (rx_rate_valid == rx_rate_code[2])
        else $error("rate valid wrong");
    coll_off_a: assert property (
        collision_detect_en == (collision_threshold != 2'h3))
        else $error("collision enable wrong");
    upper_zero_a: assert property (rd_s |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    ctrl_rsvd_a: assert property (
        (rd_s ##0 paddr == 10'h0D4) |-> prdata[5:4] == 2'h0)
        else $error("control reserved bits set");
    input_rsvd_a: assert property (
        (rd_s ##0 paddr == 10'h0E0) |-> prdata[3:2] == 2'h0)
        else $error("input reserved bits set");
    rx_on_a: assert property (tx_end |=> receiver_active)
        else $error("receiver not started");
    dec_gate_a: assert property (decoder_enable |-> receiver_active)
        else $error("decoder on while idle");
    reset_pulse_a: assert property (fifo_reset |=> !fifo_reset)
        else $error("fifo reset too long");
endmodule

// *** verification/card_model.sv ***
// Behavioural card that feeds received bytes and frame marks.
module card_model (
    input wire logic ref_clk,
    output logic sof_valid,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic byte_last,
    output logic [2:0] byte_bits,
    output logic byte_error,
    output logic collision_seen,
    output logic frame_end
);
    timeunit 1ns;
    timeprecision 1ns;
    // Marks idle low; data never shows a stale value.
    initial
    begin
        {sof_valid, byte_valid, byte_last, byte_error} = 4'h0;
        {collision_seen, frame_end, byte_bits} = 5'h00;
        byte_data = 8'h5A;
    end
    // Sends one byte, then keeps the least byte spacing.
    task automatic put(input logic [7:0] d, input logic l,
        input logic [2:0] b, input logic e, input logic c);
        @(posedge ref_clk);
        byte_valid <= 1'b1;
        byte_data <= d;
        {byte_last, byte_bits, byte_error, collision_seen} <= {l, b, e, c};
        @(posedge ref_clk);
        byte_valid <= 1'b0;
        byte_data <= ~d;
        {byte_last, byte_bits, byte_error, collision_seen} <= 6'h00;
        repeat (5) @(posedge ref_clk);
    endtask
    // Marks a frame start, or a frame end when eof is set.
    task automatic fire(input logic eof);
        @(posedge ref_clk);
        sof_valid <= !eof;
        frame_end <= eof;
        @(posedge ref_clk);
        {sof_valid, frame_end} <= 2'h0;
    endtask
endmodule

// *** verification/rx_frontend_config_tb.sv ***
// Self-checking bench for the receiver configuration block.
module rx_frontend_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic tx_end = 1'b0, crc_enable = 1'b0, pready, pslverr, rerr;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [7:0] error_snapshot = 8'h3C, byte_data, fifo_wr_data, last_wr;
    logic [2:0] transmit_data_config = 3'h4, byte_bits, rx_rate_code;
    logic sof_valid, byte_valid, byte_last, byte_error, collision_seen;
    logic frame_end, fifo_wr_valid, fifo_reset, receiver_active, irq;
    logic decoder_enable, single_input_mode, converter_mode;
    logic collision_detect_en, rx_rate_valid;
    logic [3:0] decoder_threshold, phase_detector_threshold;
    logic [1:0] signal_source_select, collision_threshold;
    int n_mismatch, cmp_count, n_wr, n_rst;
    rx_frontend_config dut (.*);
    card_model card (.*);
    // Clock, and a watchdog well beyond the expected run.
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
    // Counts FIFO writes and FIFO resets.
    always @(posedge ref_clk)
    begin
        if (fifo_wr_valid === 1'b1)
        begin
            n_wr++;
            last_wr = fifo_wr_data;
        end
        if (fifo_reset === 1'b1)
            n_rst++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'h0, 24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge ref_clk);
    endtask
    task automatic go;
        @(posedge ref_clk);
        tx_end <= 1'b1;
        @(posedge ref_clk);
        tx_end <= 1'b0;
    endtask
    task automatic t_regs;
        logic [7:0] m [4];
        m = '{8'hCF, 8'hFF, 8'hFF, 8'hF3};
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 8'h35 + 8'(i), 8'h00);
            chk(rdat, 0);
            apb(1, 8'h35 + 8'(i), 8'hFF);
            apb(0, 8'h35 + 8'(i), 8'h00);
            chk(rdat, {24'h0, m[i]});
        end
        apb(1, 8'h37, 8'hA5);
        chk({decoder_threshold, phase_detector_threshold},
            8'hA5);
        apb(1, 8'h38, 8'hC0);
        chk({single_input_mode, converter_mode}, 2'h3);
        for (int i = 0; i < 8; i++)
        begin
            apb(1, 8'h35, 8'(i));
            chk(rx_rate_valid, i > 3);
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1, 8'h38, 8'(i * 17));
            chk({signal_source_select, collision_threshold}, i * 5);
            chk(collision_detect_en, i != 3);
        end
        apb(0, 8'h00, 8'h00);
        chk({rdat[30:0], rerr}, 32'h1);
    endtask
    task automatic t_blank;
        int hb [4];
        int n;
        hb = '{rx_cfg_pkg::HB_106_CYC, rx_cfg_pkg::HB_212_CYC,
            rx_cfg_pkg::HB_424_CYC, rx_cfg_pkg::HB_847_CYC};
        for (int k = -1; k < 4; k++)
        begin
            transmit_data_config <= 3'(k + 4);
            apb(1, 8'h36, k < 0 ? 8'h02 : 8'h81);
            go();
            for (n = 0; n < 999; n++)
            begin
                @(posedge ref_clk);
                if (decoder_enable === 1'b1)
                    break;
            end
            chk(n, k < 0 ? 2 * rx_cfg_pkg::FINE_UNIT_CYC : hb[k]);
        end
    endtask
    task automatic t_stream;
        n_wr = 0;
        apb(1, 8'h36, 8'h00);
        apb(1, 8'h35, 8'h44);
        go();
        card.put(8'hA5, 0, 0, 0, 0);
        card.fire(1);
        repeat (4) @(posedge ref_clk);
        chk(n_wr, 2);
        chk(last_wr, error_snapshot);
        chk(receiver_active, 1);
        apb(1, 8'h35, 8'h84);
        crc_enable <= 1'b1;
        card.put(8'hC3, 1, 3, 0, 0);
        apb(1, 8'h35, 8'h04);
        card.put(8'h3C, 1, 3, 0, 0);
        chk(n_wr, 3);
        card.fire(1);
        crc_enable <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(receiver_active, 0);
        apb(1, 8'h51, 8'h01);
        chk(irq, 1);
        apb(1, 8'h51, 8'h00);
        chk(irq, 0);
        apb(1, 8'h51, 8'h01);
        apb(0, 8'h50, 8'h00);
        chk({irq, rdat[0]}, 2'h1);
    endtask
    task automatic t_suppress;
        n_wr = 0;
        n_rst = 0;
        apb(1, 8'h38, 8'h10);
        apb(1, 8'h35, 8'h0C);
        go();
        card.put(8'h11, 0, 0, 0, 0);
        card.put(8'h22, 0, 0, 1, 0);
        card.put(8'h33, 0, 0, 0, 1);
        chk({n_rst[15:0], n_wr[15:0]}, 32'h20000);
        for (int i = 1; i < 4; i++)
            card.put(8'(i), 0, 0, 0, 0);
        card.fire(1);
        chk({n_wr[23:0], last_wr}, 32'h303);
        apb(0, 8'h50, 8'h00);
        go();
        card.fire(0);
        card.put(8'h44, 0, 0, 0, 0);
        card.fire(1);
        repeat (4) @(posedge ref_clk);
        chk({irq, n_wr[30:0]}, 3);
        apb(0, 8'h50, 8'h00);
        chk(rdat[0], 0);
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Reset for ten cycles, then run each scenario.
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs();
        t_blank();
        t_stream();
        t_suppress();
        close_out();
    end
endmodule
bind rx_frontend_config rx_cfg_monitor mon (.*);
